/* logic/sfepc_top.sv */
// Command, protection and erase sequencer of a multi-lane serial flash.
// Assumes the link pins arrive asynchronous and are oversampled by i_clk.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
module sfepc_top #(
    parameter int BUSY_CYC = sfepc_pkg::BUSY_CYCLES  // Busy cycles per operation
) (
    input  wire logic                         i_clk,         // System clock
    input  wire logic                         i_resetn,      // Async reset, low
    input  wire logic                         i_pin_reset_n, // Reset pin, low
    input  wire logic                         i_sck,         // Serial clock
    input  wire logic                         i_cs_n,        // Chip select, low
    input  wire logic [3:0]                   i_io,          // Data lines in
    output logic      [3:0]                   o_io,          // Data lines out
    output logic      [3:0]                   o_io_oe_n,     // Low while driving
    input  wire logic [3:0]                   i_addr,        // Register address
    input  wire logic [31:0]                  i_wdata,       // Register write data
    input  wire logic                         i_wr,          // Write strobe
    input  wire logic                         i_rd,          // Read strobe
    output logic      [31:0]                  o_rdata,       // Read data, next cycle
    output logic                              o_op_done,     // Operation finished
    output logic                              o_op_erase,    // Op was an erase
    output logic      [1:0]                   o_op_size,     // Erase span code
    output logic      [sfepc_pkg::ADDR_W-1:0] o_op_addr      // Op base address
);
    import sfepc_pkg::*;
    localparam int CNT_W = $clog2(BUSY_CYC + 1);
    if (BUSY_CYC < 1) begin : g_chk
        $error("BUSY_CYC must be at least one");
    end

    function automatic logic [ADDR_W-1:0] span_mask(input logic [1:0] sz);
        unique case (sz)
            SZ_4K:   span_mask = ADDR_W'((1 << SEC4_LOG2) - 1);
            SZ_32K:  span_mask = ADDR_W'((1 << PGRP_LOG2) - 1);
            SZ_64K:  span_mask = ADDR_W'((1 << SEC64_LOG2) - 1);
            SZ_256K: span_mask = ADDR_W'((1 << SEC256_LOG2) - 1);
        endcase
    endfunction

    function automatic sfepc_state_type cmd_next(input logic [7:0] op);
        unique case (op)
            OP_PAGE_PROG, OP_OTP_PROG, OP_ERASE_4K, OP_ERASE_BIG,
            OP_FAST_READ, OP_EVAL_ERASE:                cmd_next = ST_ADDR;
            OP_REG_WRITE:                               cmd_next = ST_DATA;
            OP_RD_STATUS1, OP_RD_STATUS2, OP_RD_CONFIG: cmd_next = ST_OUT;
            default:                                    cmd_next = ST_SKIP;
        endcase
    endfunction

    // Pin sampling: reset pin, cs, sck, four data lines
    logic [6:0]  sync1_r;
    logic [6:0]  sync2_r;
    logic        sck_prev_r;
    logic        cs_prev_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r    <= 7'h60;
            sync2_r    <= 7'h60;
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
        end else begin
            sync1_r    <= {i_pin_reset_n, i_cs_n, i_sck, i_io};
            sync2_r    <= sync1_r;
            sck_prev_r <= sync2_r[4];
            cs_prev_r  <= sync2_r[5];
        end
    end
    wire       cs_n_s    = sync2_r[5];
    wire       prst_s    = ~sync2_r[6];
    wire [3:0] io_s      = sync2_r[3:0];
    wire       sck_rise  = sync2_r[4] & ~sck_prev_r & ~cs_n_s;
    wire       sck_fall  = ~sync2_r[4] & sck_prev_r & ~cs_n_s;
    wire       frame_end = cs_n_s & ~cs_prev_r;

    sfepc_state_type   state_r;
    logic [7:0]        sh_r;
    logic [7:0]        op_r;
    logic [7:0]        out_r;
    logic [7:0]        wd0_r;
    logic [7:0]        wd1_r;
    logic [2:0]        bit_r;
    logic [1:0]        nbyte_r;
    logic [3:0]        dummy_r;
    logic [ADDR_W-1:0] addr_r;
    logic              out_hold_r;
    logic              four_r;
    logic [31:0]       ctrl_r;
    logic [7:0]        sr1;
    logic [7:0]        cr1;
    logic [7:0]        sr2;
    logic              wel_r, wip_r, perr_r, eerr_r, srwd_r;
    logic [2:0]        bp_r;
    logic              freeze_r, quad_r, ptop_r, bpvol_r, ptb_r;
    logic              eok_r, last_ok_r;
    logic [1:0]        last_sz_r;
    logic [ADDR_W-1:0] last_base_r;
    logic              run_r, run_erase_r, run_fail_r;
    logic [CNT_W-1:0]  cnt_r;

    // In four-wide mode all four lines, IO3 included, are data; IO3 never pauses a transfer
    wire [7:0] byte_in   = four_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
    wire       byte_done = four_r ? bit_r[0] : (bit_r == 3'h7);
    wire [3:0] lat       = ctrl_r[CTRL_LAT_HI:CTRL_LAT_LO];
    wire [7:0] reg_byte  = (byte_in == OP_RD_STATUS2) ? sr2 :
                           (byte_in == OP_RD_CONFIG)  ? cr1 : sr1;

    // Serial framing
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r    <= ST_CMD;
            sh_r       <= 8'h00;
            op_r       <= 8'h00;
            out_r      <= 8'h00;
            wd0_r      <= 8'h00;
            wd1_r      <= 8'h00;
            bit_r      <= 3'h0;
            nbyte_r    <= 2'h0;
            dummy_r    <= 4'h0;
            addr_r     <= '0;
            out_hold_r <= 1'b0;
        end else if (cs_n_s || prst_s) begin
            state_r    <= ST_CMD;
            bit_r      <= 3'h0;
            nbyte_r    <= 2'h0;
            out_hold_r <= 1'b0;
        end else if (sck_rise && state_r == ST_DUMMY) begin
            dummy_r <= dummy_r - 4'h1;
            if (dummy_r == 4'h1) begin
                state_r    <= ST_OUT;
                out_r      <= FILL_BYTE;
                out_hold_r <= 1'b1;
            end
        end else if (sck_rise) begin
            sh_r  <= byte_in;
            bit_r <= byte_done ? 3'h0 : bit_r + 3'h1;
            if (byte_done) begin
                unique case (state_r)
                    ST_CMD: begin
                        op_r       <= byte_in;
                        state_r    <= cmd_next(byte_in);
                        out_r      <= reg_byte;
                        out_hold_r <= 1'b1;
                    end
                    ST_ADDR: begin
                        addr_r  <= {addr_r[15:0], byte_in};
                        nbyte_r <= nbyte_r + 2'h1;
                        if (nbyte_r == 2'h2) begin
                            nbyte_r    <= 2'h0;
                            dummy_r    <= lat;
                            out_r      <= FILL_BYTE;
                            out_hold_r <= 1'b1;
                            if (op_r != OP_FAST_READ) begin
                                state_r <= ST_DATA;
                            end else begin
                                state_r <= (lat == 4'h0) ? ST_OUT : ST_DUMMY;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (nbyte_r == 2'h0) begin
                            wd0_r <= byte_in;
                        end else if (nbyte_r == 2'h1) begin
                            wd1_r <= byte_in;
                        end
                        if (nbyte_r != 2'h3) begin
                            nbyte_r <= nbyte_r + 2'h1;
                        end
                    end
                    ST_DUMMY, ST_OUT, ST_SKIP: begin
                    end
                endcase
            end
        end else if (sck_fall && state_r == ST_OUT) begin
            // First fall after loading keeps the leading bit on the line
            out_hold_r <= 1'b0;
            if (!out_hold_r) begin
                out_r <= four_r ? {out_r[3:0], out_r[7:4]} : {out_r[6:0], out_r[7]};
            end
        end
    end

    // Pin drivers
    wire       drive  = ~cs_n_s & (state_r == ST_OUT);
    wire [3:0] io_nxt = four_r ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
    wire [3:0] oe_nxt = !drive ? 4'hf : (four_r ? 4'h0 : 4'hd);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_io      <= 4'h0;
            o_io_oe_n <= 4'hf;
        end else begin
            o_io      <= io_nxt;
            o_io_oe_n <= oe_nxt;
        end
    end

    // Register images
    always_comb begin
        sr1 = 8'h00;
        sr1[SR_WRITE_IN_PROGRESS] = wip_r;
        sr1[SR_WEL] = wel_r;
        sr1[SR_BP_HI:SR_BP_LO] = bp_r;
        sr1[SR_ERASE_ERR] = eerr_r;
        sr1[SR_PROG_ERR] = perr_r;
        sr1[SR_SRWD] = srwd_r;
        cr1 = 8'h00;
        cr1[CFG_FREEZE] = freeze_r;
        cr1[CFG_QUAD] = quad_r;
        cr1[CFG_PARAM_LOC] = ptop_r;
        cr1[CFG_BP_VOLAT] = bpvol_r;
        cr1[CFG_PROT_TB] = ptb_r;
        sr2 = 8'h00;
        sr2[SR2_ERASE_OK] = eok_r;
    end

    // Command decode at frame end
    wire [1:0] layout   = ctrl_r[CTRL_LAYOUT_HI:CTRL_LAYOUT_LO];
    wire       adv_prot = ctrl_r[CTRL_ADVPROT];
    wire       hybrid   = layout == LAYOUT_HYBRID;
    wire       uni256   = layout == LAYOUT_UNI256;
    wire       go       = frame_end & (state_r != ST_CMD) & (bit_r == 3'h0);
    wire       is_wrr   = op_r == OP_REG_WRITE;
    wire       is_prog  = op_r == OP_PAGE_PROG;
    wire       is_otp   = op_r == OP_OTP_PROG;
    wire       is_e4    = op_r == OP_ERASE_4K;
    wire       is_ebig  = op_r == OP_ERASE_BIG;
    wire       err_held = perr_r | eerr_r;
    wire       modify   = is_wrr | is_prog | is_otp | is_e4 | is_ebig;
    wire       may_mod  = go & wel_r & ~wip_r & ~err_held;
    wire       wp_ok    = quad_r | io_s[2] | ~srwd_r;
    wire       wrr_ok   = may_mod & is_wrr & wp_ok & (state_r == ST_DATA) & (nbyte_r != 2'h0);
    wire       in_param = hybrid & (ptop_r ? &addr_r[22:PGRP_LOG2] : ~|addr_r[22:PGRP_LOG2]);
    wire       in_over  = hybrid & (ptop_r ? &addr_r[22:SEC64_LOG2] : ~|addr_r[22:SEC64_LOG2]);
    // Protected range doubles per level from 64 KB to 2 MB; the top level covers the whole array
    wire [4:0]        prot_sh = 5'(PGRP_LOG2) + {2'b00, bp_r};
    wire [ADDR_W-1:0] a_hi    = addr_r >> prot_sh;
    wire [ADDR_W-1:0] top_hi  = DEV_LAST >> prot_sh;
    wire prot_hit = (bp_r != 3'h0) & ((&bp_r) | (ptb_r ? a_hi == '0 : a_hi == top_hi));
    wire start_prog  = may_mod & (is_prog | is_otp);
    wire prog_block  = is_prog ? prot_hit : freeze_r;
    wire start_erase = may_mod & ((is_e4 & in_param) | is_ebig);
    wire [1:0] e_sz  = is_e4 ? SZ_4K : uni256 ? SZ_256K : in_over ? SZ_32K : SZ_64K;
    // Overlaid sector: erase the half away from the parameter group
    wire [ADDR_W-1:0] e_base = (e_sz == SZ_32K) ? {addr_r[23:SEC64_LOG2], ~ptop_r, 15'h0000} :
                               (addr_r & ~span_mask(e_sz));
    wire eval_hit = last_ok_r & (((addr_r ^ last_base_r) & ~span_mask(last_sz_r)) == '0);
    wire op_end   = run_r & (cnt_r == CNT_W'(1));
    wire clr_err  = go & (op_r == OP_CLEAR_STAT) & err_held;
    wire set_perr = start_prog & prog_block | op_end & run_fail_r & ~run_erase_r;
    wire set_eerr = start_erase & prot_hit | op_end & run_fail_r & run_erase_r;

    // Status, configuration and operation sequencing
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wel_r <= 1'b0;
            wip_r <= 1'b0;
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
            srwd_r <= 1'b0;
            bp_r <= 3'h0;
            freeze_r <= 1'b0;
            quad_r <= 1'b0;
            ptop_r <= 1'b0;
            bpvol_r <= 1'b0;
            ptb_r <= 1'b0;
            four_r <= 1'b0;
            eok_r <= 1'b0;
            last_ok_r <= 1'b0;
            last_sz_r <= SZ_4K;
            last_base_r <= '0;
            run_r <= 1'b0;
            run_erase_r <= 1'b0;
            run_fail_r <= 1'b0;
            cnt_r <= '0;
            o_op_done <= 1'b0;
            o_op_erase <= 1'b0;
            o_op_size <= SZ_4K;
            o_op_addr <= '0;
        end else begin
            o_op_done <= op_end & ~run_fail_r;
            // A new error wins over a clear in the same cycle
            perr_r <= (perr_r & ~clr_err) | set_perr;
            eerr_r <= (eerr_r & ~clr_err) | set_eerr;
            if (start_prog | start_erase) begin
                wip_r <= 1'b1;
            end else if (clr_err | (op_end & ~run_fail_r)) begin
                wip_r <= 1'b0;
            end
            if (go && op_r == OP_WRITE_EN) begin
                wel_r <= 1'b1;
            end else if (go && modify && !wip_r) begin
                wel_r <= 1'b0;
            end
            if (prst_s) begin
                four_r <= 1'b0;
            end else if (go && op_r == OP_FOUR_ENTER && quad_r) begin
                four_r <= 1'b1;
            end else if (go && op_r == OP_FOUR_EXIT) begin
                four_r <= 1'b0;
            end
            if (wrr_ok) begin
                srwd_r <= wd0_r[SR_SRWD];
                if (!freeze_r) begin
                    bp_r <= wd0_r[SR_BP_HI:SR_BP_LO];
                end
                if (nbyte_r != 2'h1) begin
                    quad_r   <= wd1_r[CFG_QUAD];
                    freeze_r <= freeze_r | wd1_r[CFG_FREEZE];
                    if (!freeze_r && !adv_prot) begin
                        ptop_r  <= ptop_r | wd1_r[CFG_PARAM_LOC];
                        bpvol_r <= bpvol_r | wd1_r[CFG_BP_VOLAT];
                        ptb_r   <= ptb_r | wd1_r[CFG_PROT_TB];
                    end
                end
            end
            if (go && op_r == OP_EVAL_ERASE) begin
                eok_r <= eval_hit;
            end
            if ((start_prog & ~prog_block) | (start_erase & ~prot_hit)) begin
                run_r       <= 1'b1;
                run_erase_r <= start_erase;
                run_fail_r  <= ctrl_r[CTRL_FAIL];
                cnt_r       <= CNT_W'(BUSY_CYC);
                o_op_erase  <= start_erase;
                o_op_size   <= e_sz;
                o_op_addr   <= start_erase ? e_base : addr_r;
            end else if (run_r) begin
                cnt_r <= cnt_r - CNT_W'(1);
                if (op_end) begin
                    run_r <= 1'b0;
                end
            end
            // An erase counts as good only once it has run to its end
            if (start_erase & ~prot_hit) begin
                last_ok_r   <= 1'b0;
                last_sz_r   <= e_sz;
                last_base_r <= e_base;
            end else if (op_end & run_erase_r) begin
                last_ok_r <= ~run_fail_r;
            end
        end
    end

    // Software register port
    wire [31:0] stat_word = {8'h00, sr2, cr1, sr1};
    wire [31:0] last_word = {last_ok_r, last_sz_r, 5'h00, last_base_r};
    wire [31:0] rd_mux = (i_addr == REG_CTRL) ? ctrl_r :
                         (i_addr == REG_STAT) ? stat_word :
                         (i_addr == REG_LAST) ? last_word : 32'h00000000;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r  <= CTRL_RST;
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 32'h00000000;
            if (i_wr && i_addr == REG_CTRL) begin
                ctrl_r <= {24'h000000, i_wdata[7:0]};
            end
        end
    end
endmodule
`default_nettype wire

/* logic/sfepc_pkg.sv */
// Constants, field positions and types for the flash command sequencer.
// Assumes a 100 MHz system clock that samples the serial link pins.
`default_nettype none
package sfepc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W  = 24;
    // Opcodes
    localparam logic [7:0] OP_REG_WRITE   = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_RD_STATUS1  = 8'h05;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_RD_STATUS2  = 8'h07;
    localparam logic [7:0] OP_FAST_READ   = 8'h0b;
    localparam logic [7:0] OP_ERASE_4K    = 8'h20;
    localparam logic [7:0] OP_CLEAR_STAT  = 8'h30;
    localparam logic [7:0] OP_RD_CONFIG   = 8'h35;
    localparam logic [7:0] OP_FOUR_ENTER  = 8'h38;
    localparam logic [7:0] OP_OTP_PROG    = 8'h42;
    localparam logic [7:0] OP_EVAL_ERASE  = 8'hd0;
    localparam logic [7:0] OP_ERASE_BIG   = 8'hd8;
    localparam logic [7:0] OP_FOUR_EXIT   = 8'hf5;
    localparam logic [7:0] FILL_BYTE      = 8'hff;
    // Status one and status two bits
    localparam int SR_WRITE_IN_PROGRESS = 0;
    localparam int SR_WEL    = 1;
    localparam int SR_BP_LO  = 2;
    localparam int SR_BP_HI  = 4;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR  = 6;
    localparam int SR_SRWD   = 7;
    localparam int SR2_ERASE_OK = 2;
    // Config one bits
    localparam int CFG_FREEZE    = 0;
    localparam int CFG_QUAD      = 1;
    localparam int CFG_PARAM_LOC = 2;
    localparam int CFG_BP_VOLAT  = 3;
    localparam int CFG_PROT_TB   = 5;
    // Sector geometry
    localparam int SEC4_LOG2   = 12;
    localparam int PGRP_LOG2   = 15;
    localparam int SEC64_LOG2  = 16;
    localparam int SEC256_LOG2 = 18;
    localparam logic [ADDR_W-1:0] DEV_LAST = 24'h7fffff;
    localparam logic [1:0] LAYOUT_HYBRID = 2'h0;
    localparam logic [1:0] LAYOUT_UNI256 = 2'h2;
    localparam logic [1:0] SZ_4K   = 2'h0;
    localparam logic [1:0] SZ_32K  = 2'h1;
    localparam logic [1:0] SZ_64K  = 2'h2;
    localparam logic [1:0] SZ_256K = 2'h3;
    // Register port map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_LAST = 4'h8;
    localparam int CTRL_LAYOUT_LO = 0;
    localparam int CTRL_LAYOUT_HI = 1;
    localparam int CTRL_ADVPROT   = 2;
    localparam int CTRL_FAIL      = 3;
    localparam int CTRL_LAT_LO    = 4;
    localparam int CTRL_LAT_HI    = 7;
    localparam logic [31:0] CTRL_RST = 32'h00000080;
    // Internal operation time
    localparam int BUSY_TIME_NS = 1000;
    localparam int BUSY_CYCLES  = (BUSY_TIME_NS * CLK_MHZ) / 1000;
    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA, ST_DUMMY, ST_OUT, ST_SKIP}
        sfepc_state_type;
endpackage
`default_nettype wire

/* tb/sfepc_sva.sv */
// Port assertions for the flash command sequencer.
// Assumes it is bound onto sfepc_top and sees only its ports.
`default_nettype none
module sfepc_sva
    import sfepc_pkg::*;
(
    input wire logic                         i_clk,      // System clock
    input wire logic                         i_resetn,   // Async reset, low
    input wire logic                         i_cs_n,     // Chip select, low
    input wire logic [3:0]                   i_addr,     // Register address
    input wire logic                         i_rd,       // Read strobe
    input wire logic [3:0]                   o_io_oe_n,  // Lane enables, low
    input wire logic [31:0]                  o_rdata,    // Read data
    input wire logic                         o_op_done,  // Op finished
    input wire logic                         o_op_erase, // Op was erase
    input wire logic [1:0]                   o_op_size,  // Erase span
    input wire logic [sfepc_pkg::ADDR_W-1:0] o_op_addr   // Op base
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Eight idle cycles cover the pin synchronisers
    sequence s_link_idle;
        i_cs_n [*8];
    endsequence
    a_idle_release: assert property (s_link_idle |-> o_io_oe_n == 4'hf)
        else $error("lines driven while deselected");
    a_oe_lanes: assert property (o_io_oe_n inside {4'hf, 4'hd, 4'h0})
        else $error("illegal lane enable mix");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > REG_LAST
        |-> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_done_pulse: assert property (o_op_done |=> !o_op_done)
        else $error("done longer than one cycle");
    a_erase_param: assert property (o_op_erase && o_op_size == SZ_4K |->
        o_op_addr[11:0] == 12'h0 && o_op_addr[22:15] inside {8'h00, 8'hff})
        else $error("small erase outside parameter group");
    a_erase_half: assert property (o_op_erase && o_op_size == SZ_32K |->
        o_op_addr[14:0] == 15'h0 && o_op_addr[22:16] inside {7'h00, 7'h7f})
        else $error("half erase not next to group");
    a_erase_big: assert property (o_op_erase && o_op_size == SZ_64K
        |-> o_op_addr[15:0] == 16'h0)
        else $error("big erase base unaligned");
    a_erase_huge: assert property (o_op_erase && o_op_size == SZ_256K
        |-> o_op_addr[17:0] == 18'h0)
        else $error("huge erase base unaligned");
endmodule
bind sfepc_top sfepc_sva u_sfepc_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
    .i_addr(i_addr), .i_rd(i_rd), .o_io_oe_n(o_io_oe_n), .o_rdata(o_rdata),
    .o_op_done(o_op_done), .o_op_erase(o_op_erase), .o_op_size(o_op_size),
    .o_op_addr(o_op_addr));
`default_nettype wire

/* tb/sfepc_host.sv */
// Host side of the serial link, mode 0, 80 ns clock.
// Assumes the bench resolves lane levels from the device lane enables.
`default_nettype none
module sfepc_host (
    output logic            o_sck,  // Serial clock, idle low
    output logic            o_cs_n, // Select, low
    output logic [3:0]      o_io,   // Host lane levels
    input  wire logic [3:0] i_io    // Resolved lanes
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'hd;
    end
    // Whole bytes only, so a frame ends on a byte boundary
    task automatic frame(input logic [7:0] b[$], input bit rd_en, output logic [7:0] rd);
        o_cs_n = 1'b0;
        foreach (b[i]) for (int k = 7; k >= 0; k--) begin
            o_io[0] = b[i][k];
            #40 o_sck = 1'b1;
            #40 o_sck = 1'b0;
        end
        rd = 8'h00;
        if (rd_en) for (int k = 7; k >= 0; k--) begin
            #40 o_sck = 1'b1;
            #5 rd[k] = i_io[1];
            #35 o_sck = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        // Released line shows the opposite level, never a stale one
        o_io[1:0] = ~o_io[1:0];
        #200;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the flash command sequencer.
// Assumes sfepc_host drives the link and the checker is bound in.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sfepc_pkg::*;
    typedef struct {logic [31:0] ctrl; logic [7:0] op; logic [23:0] a; int done;
        logic [1:0] sz; logic [23:0] base;} sfepc_row_type;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        sck, cs_n, o_op_done, o_op_erase;
    logic [3:0]  host_io, o_io, o_io_oe_n, link_io;
    logic [31:0] o_rdata, v;
    logic [1:0]  o_op_size;
    logic [23:0] o_op_addr;
    logic [7:0]  r;
    int          error_cnt = 0, check_count = 0, done_cnt = 0, n;
    sfepc_row_type rows [7] = '{
        '{32'h80, OP_ERASE_4K, 24'h001234, 1, SZ_4K, 24'h001000},
        '{32'h80, OP_ERASE_BIG, 24'h008100, 1, SZ_32K, 24'h008000},
        '{32'h80, OP_ERASE_BIG, 24'h123456, 1, SZ_64K, 24'h120000},
        '{32'h81, OP_ERASE_BIG, 24'h123456, 1, SZ_64K, 24'h120000},
        '{32'h82, OP_ERASE_BIG, 24'h123456, 1, SZ_256K, 24'h100000},
        '{32'h80, OP_ERASE_4K, 24'h400000, 0, SZ_256K, 24'h100000},
        '{32'h80, 8'h52, 24'h123456, 0, SZ_256K, 24'h100000}};
    always #5 i_clk = ~i_clk;
    assign link_io = (o_io & ~o_io_oe_n) | (host_io & o_io_oe_n);
    always @(posedge i_clk) if (o_op_done === 1'b1) done_cnt++;
    sfepc_top #(.BUSY_CYC(4)) u_sfepc_top (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_pin_reset_n(1'b1), .i_sck(sck), .i_cs_n(cs_n), .i_io(link_io), .o_io(o_io),
        .o_io_oe_n(o_io_oe_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_op_done(o_op_done), .o_op_erase(o_op_erase),
        .o_op_size(o_op_size), .o_op_addr(o_op_addr));
    sfepc_host u_sfepc_host (.o_sck(sck), .o_cs_n(cs_n), .o_io(host_io), .i_io(link_io));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Every modifying command needs its own write enable first
    task automatic cmd(input logic [7:0] b[$]);
        u_sfepc_host.frame('{OP_WRITE_EN}, 1'b0, r);
        u_sfepc_host.frame(b, 1'b0, r);
        repeat (20) @(posedge i_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500us;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        foreach (rows[i]) begin
            wr(REG_CTRL, rows[i].ctrl);
            n = done_cnt;
            cmd('{rows[i].op, rows[i].a[23:16], rows[i].a[15:8], rows[i].a[7:0]});
            check(32'(done_cnt - n), 32'(rows[i].done));
            check({5'h0, o_op_erase, o_op_size, o_op_addr},
                  {5'h0, 1'b1, rows[i].sz, rows[i].base});
            $display("row %0d done", i);
        end
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(REG_STAT, v);
        check(v, 32'h0);
        rd(REG_CTRL, v);
        check(v, CTRL_RST);
        rd(4'hc, v);
        check(v, 32'h0);
        $display("reset test done");
        wr(REG_CTRL, CTRL_RST | 32'h8);
        cmd('{OP_ERASE_BIG, 8'h20, 8'h00, 8'h00});
        wr(REG_CTRL, CTRL_RST);
        rd(REG_STAT, v);
        check(v & 32'h21, 32'h21);
        u_sfepc_host.frame('{OP_RD_STATUS1}, 1'b1, r);
        check({24'h0, r & 8'h21}, 32'h21);
        n = done_cnt;
        cmd('{OP_ERASE_BIG, 8'h30, 8'h00, 8'h00});
        check(32'(done_cnt - n), 32'h0);
        u_sfepc_host.frame('{OP_CLEAR_STAT}, 1'b0, r);
        rd(REG_STAT, v);
        check(v & 32'h61, 32'h0);
        cmd('{OP_ERASE_BIG, 8'h30, 8'h00, 8'h00});
        check(32'(done_cnt - n), 32'h1);
        u_sfepc_host.frame('{OP_EVAL_ERASE, 8'h30, 8'h00, 8'h00}, 1'b0, r);
        u_sfepc_host.frame('{OP_RD_STATUS2}, 1'b1, r);
        check({24'h0, r}, 32'h4);
        $display("error test done");
        cmd('{OP_REG_WRITE, 8'h00, 8'h02});
        cmd('{OP_REG_WRITE, 8'h04});
        rd(REG_STAT, v);
        check({20'h0, v[15:8], 1'b0, v[4:2]}, {20'h0, 8'h02, 4'h1});
        cmd('{OP_REG_WRITE, 8'h04, 8'h03});
        cmd('{OP_REG_WRITE, 8'h1c, 8'h2e});
        rd(REG_STAT, v);
        check({20'h0, v[15:8], 1'b0, v[4:2]}, {20'h0, 8'h03, 4'h1});
        n = done_cnt;
        cmd('{OP_OTP_PROG, 8'h00, 8'h00, 8'h10, 8'h55});
        check(32'(done_cnt - n), 32'h0);
        rd(REG_STAT, v);
        check(v & 32'h41, 32'h41);
        // Latched error would refuse the next erase, so clear it first
        u_sfepc_host.frame('{OP_CLEAR_STAT}, 1'b0, r);
        cmd('{OP_ERASE_BIG, 8'h7f, 8'h00, 8'h00});
        rd(REG_STAT, v);
        check(v & 32'h61, 32'h21);
        $display("protect test done");
        end_sim();
    end
endmodule
`default_nettype wire
